// >>> src/tqff_pkg.sv
// package for the torque feedforward and two-degree-of-freedom block
// assumes a 250 MHz pclk and a 32-bit APB master
package tqff_pkg;
   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [11:0] TQFF_ADDR_SRC_SEL = 12'h000;
   localparam logic [11:0] TQFF_ADDR_FF_GAIN = 12'h004;
   localparam logic [11:0] TQFF_ADDR_FF_FILT = 12'h008;
   localparam logic [11:0] TQFF_ADDR_TDOF_COEF = 12'h00c;
   localparam logic [11:0] TQFF_ADDR_STATUS = 12'h010;
   localparam logic [11:0] TQFF_ADDR_FF_TERM = 12'h014;
   localparam logic [11:0] TQFF_ADDR_TQ_OUT = 12'h018;
   // ************************************************************
   // field layout and reset values
   // ************************************************************
   localparam int TQFF_POL_BIT = 5;
   localparam logic [1:0] TQFF_SRC_NONE = 2'h0;
   localparam logic [1:0] TQFF_SRC_INTERNAL = 2'h1;
   localparam logic [1:0] TQFF_SRC_EXTERNAL = 2'h2;
   localparam logic [15:0] TQFF_GAIN_RST = 16'h0000;
   localparam logic [15:0] TQFF_FILT_RST = 16'h0000;
   // coefficient in tenths of a percent: 1000 is 100.0
   localparam logic [15:0] TQFF_TDOF_FULL = 16'h03e8;
   // feedforward gain is in tenths of a percent: 1000 is unity
   localparam logic [15:0] TQFF_GAIN_UNITY = 16'h03e8;
   localparam logic [15:0] TQFF_TQ_MAX = 16'h7fff;
   localparam logic [15:0] TQFF_TQ_MIN = 16'h8000;
   localparam logic [1:0] TQFF_MODE_POS = 2'h0;
   localparam logic [1:0] TQFF_MODE_SPD = 2'h1;
   localparam logic [1:0] TQFF_MODE_TRQ = 2'h2;
   localparam logic [31:0] TQFF_RDATA_ZERO = 32'h0000_0000;
endpackage : tqff_pkg

// >>> src/tqff_loop.sv
// torque feedforward path and two-degree-of-freedom selection
// assumes samples arrive with sample_en, same clock, from the speed regulator
//
// Function
// (R1) feedforward active only when the source selection is non-zero
// (R2) source one derives feedforward from the speed command
// (R3) in position mode the speed command is the position controller output
// (R4) source two uses the external torque offset in 0.1 percent
// (R5) with external source, polarity bit five inverts the feedforward sign
// (R6) feedforward term applied only for non-zero gain, scaled by it
// (R7) gain and filter time are separately settable
// (R8) coefficient 100.0 keeps plain proportional-integral velocity loop
// (R9) other coefficients select two-degree-of-freedom, except in torque mode
// (R10) operator raises gain from zero with filter at default
// (R11) scaled filtered term adds to regulator torque, saturated
`timescale 1ns/100ps
module tqff_loop
   import tqff_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_en,
   input wire logic [1:0] ctrl_mode,
   input wire logic [15:0] speed_cmd,
   input wire logic [15:0] pos_ctrl_out,
   input wire logic [15:0] torque_offset,
   input wire logic [7:0] polarity,
   input wire logic [15:0] reg_torque,
   output logic [15:0] torque_out,
   output logic [15:0] ff_term,
   output logic tdof_active,
   output logic tdof_coef_valid,
   output logic [15:0] tdof_coef_out
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [1:0] src_sel;
   logic [15:0] ff_gain;
   logic [15:0] ff_filt;
   logic [15:0] tdof_coef;
   logic [15:0] filt_acc;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic sel_src;
   logic sel_gain;
   logic sel_filt;
   logic sel_coef;
   logic sel_status;
   logic sel_term;
   logic sel_tq;
   logic [31:0] next_prdata;

   // zero wait states: every access ends in its first access cycle
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   // read data captured in setup so it stands through the access phase
   assign rd_en = psel & ~penable & ~pwrite;

   // ************************************************************
   // address decode
   // ************************************************************
   always_comb begin
      sel_src = 1'b0;
      sel_gain = 1'b0;
      sel_filt = 1'b0;
      sel_coef = 1'b0;
      sel_status = 1'b0;
      sel_term = 1'b0;
      sel_tq = 1'b0;
      if (paddr == TQFF_ADDR_SRC_SEL) begin
         sel_src = 1'b1;
      end else if (paddr == TQFF_ADDR_FF_GAIN) begin
         sel_gain = 1'b1;
      end else if (paddr == TQFF_ADDR_FF_FILT) begin
         sel_filt = 1'b1;
      end else if (paddr == TQFF_ADDR_TDOF_COEF) begin
         sel_coef = 1'b1;
      end else if (paddr == TQFF_ADDR_STATUS) begin
         sel_status = 1'b1;
      end else if (paddr == TQFF_ADDR_FF_TERM) begin
         sel_term = 1'b1;
      end else if (paddr == TQFF_ADDR_TQ_OUT) begin
         sel_tq = 1'b1;
      end
   end

   assign addr_ok = sel_src | sel_gain | sel_filt | sel_coef | sel_status | sel_term | sel_tq;
   // unmapped addresses answer with an error and change nothing
   assign pslverr = psel & penable & ~addr_ok;

   // ************************************************************
   // settable parameters, one block each
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_sel <= TQFF_SRC_NONE;
      end else if (wr_en && sel_src) begin
         src_sel <= pwdata[1:0]; // see (R1)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ff_gain <= TQFF_GAIN_RST;
      end else if (wr_en && sel_gain) begin
         ff_gain <= pwdata[15:0]; // see (R7)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ff_filt <= TQFF_FILT_RST;
      end else if (wr_en && sel_filt) begin
         ff_filt <= pwdata[15:0]; // see (R7)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdof_coef <= TQFF_TDOF_FULL;
      end else if (wr_en && sel_coef) begin
         tdof_coef <= pwdata[15:0]; // see (R8)
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   always_comb begin
      if (sel_src) begin
         next_prdata = {30'h0, src_sel};
      end else if (sel_gain) begin
         next_prdata = {16'h0, ff_gain};
      end else if (sel_filt) begin
         next_prdata = {16'h0, ff_filt};
      end else if (sel_coef) begin
         next_prdata = {16'h0, tdof_coef};
      end else if (sel_status) begin
         next_prdata = {30'h0, tdof_coef_valid, tdof_active};
      end else if (sel_term) begin
         next_prdata = {16'h0, ff_term};
      end else if (sel_tq) begin
         next_prdata = {16'h0, torque_out};
      end else begin
         next_prdata = TQFF_RDATA_ZERO;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= TQFF_RDATA_ZERO;
      end else if (rd_en) begin
         prdata <= next_prdata;
      end
   end

   // ************************************************************
   // feedforward source
   // ************************************************************
   logic signed [15:0] ff_src;
   logic signed [15:0] spd_src;
   logic signed [15:0] ext_src;
   logic ff_on;

   always_comb begin
      ext_src = $signed(torque_offset); // see (R4)
      if (polarity[TQFF_POL_BIT]) begin
         ext_src = -$signed(torque_offset); // see (R5)
      end
   end

   always_comb begin
      spd_src = (ctrl_mode == TQFF_MODE_POS) ? pos_ctrl_out : speed_cmd; // see (R3)
      ff_src = 16'sh0000; // see (R1)
      if (src_sel == TQFF_SRC_INTERNAL) begin
         ff_src = spd_src; // see (R2)
      end else if (src_sel == TQFF_SRC_EXTERNAL) begin
         ff_src = ext_src; // see (R4)
      end
   end

   // code three selects no source, the same as code zero
   assign ff_on = (src_sel == TQFF_SRC_INTERNAL || src_sel == TQFF_SRC_EXTERNAL) // see (R1)
      && (ff_gain != 16'h0000); // see (R6)

   // ************************************************************
   // first-order filter: acc += (src - acc) >> filt
   // ************************************************************
   logic signed [16:0] filt_diff;
   logic [3:0] filt_shift;
   logic [15:0] next_filt_acc;
   assign filt_shift = (ff_filt > 16'h000f) ? 4'hf : ff_filt[3:0];
   assign filt_diff = 17'(ff_src) - 17'($signed(filt_acc));
   assign next_filt_acc = 16'($signed(filt_acc) + 16'(filt_diff >>> filt_shift)); // see (R7)

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_acc <= 16'h0000;
      end else if (sample_en) begin
         filt_acc <= next_filt_acc; // see (R7)
      end
   end

   // ************************************************************
   // gain scaling
   // ************************************************************
   logic signed [32:0] ff_prod;
   logic signed [32:0] ff_scaled;
   logic signed [16:0] next_ff;
   logic signed [17:0] tq_sum;
   logic [15:0] next_torque;
   always_comb begin
      ff_prod = 33'($signed(filt_acc)) * $signed({1'b0, ff_gain}); // see (R6)
      ff_scaled = ff_prod / $signed({17'h0, TQFF_GAIN_UNITY});
      if (ff_scaled > 33'sh0_7fff) begin
         next_ff = 17'sh0_7fff;
      end else if (ff_scaled < -33'sh0_8000) begin
         next_ff = -17'sh0_8000;
      end else begin
         next_ff = ff_scaled[16:0];
      end
      if (!ff_on) begin
         next_ff = 17'sh0_0000; // see (R1) (R6)
      end
   end

   // ************************************************************
   // torque sum
   // ************************************************************
   always_comb begin
      tq_sum = 18'($signed(reg_torque)) + 18'(next_ff); // see (R11)
      if (tq_sum > 18'($signed({1'b0, TQFF_TQ_MAX}))) begin
         next_torque = TQFF_TQ_MAX;
      end else if (tq_sum < 18'($signed({1'b1, TQFF_TQ_MIN}))) begin
         next_torque = TQFF_TQ_MIN;
      end else begin
         next_torque = tq_sum[15:0];
      end
   end

   // ************************************************************
   // sampled outputs
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ff_term <= 16'h0000;
      end else if (sample_en) begin
         ff_term <= next_ff[15:0]; // see (R6)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         torque_out <= 16'h0000;
      end else if (sample_en) begin
         torque_out <= next_torque; // see (R11)
      end
   end

   // ************************************************************
   // two-degree-of-freedom selection
   // ************************************************************
   logic non_trq;
   logic next_tdof_active;
   logic [15:0] next_tdof_coef;
   assign non_trq = (ctrl_mode != TQFF_MODE_TRQ);

   always_comb begin
      next_tdof_active = 1'b0;
      next_tdof_coef = TQFF_TDOF_FULL; // see (R9)
      if (non_trq) begin
         next_tdof_active = (tdof_coef != TQFF_TDOF_FULL); // see (R8) (R9)
         next_tdof_coef = tdof_coef;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdof_active <= 1'b0;
      end else begin
         tdof_active <= next_tdof_active; // see (R8) (R9)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdof_coef_out <= TQFF_TDOF_FULL;
      end else begin
         tdof_coef_out <= next_tdof_coef; // see (R9)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdof_coef_valid <= 1'b0;
      end else begin
         tdof_coef_valid <= 1'b1;
      end
   end
endmodule // tqff_loop

// >>> dv/tqff_loop_monitor.sv
// port checker for tqff_loop
// assumes one pclk domain, bound to every tqff_loop
`timescale 1ns/100ps
module tqff_loop_monitor
   import tqff_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sample_en,
   input wire logic [1:0] ctrl_mode,
   input wire logic [15:0] ff_term,
   input wire logic [15:0] torque_out,
   input wire logic tdof_active,
   input wire logic tdof_coef_valid,
   input wire logic [15:0] tdof_coef_out
);
   logic [1:0] src;
   logic [15:0] gain;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src <= 2'h0;
         gain <= 16'h0000;
      end else if (psel && penable && pwrite) begin
         if (paddr == TQFF_ADDR_SRC_SEL) src <= pwdata[1:0];
         if (paddr == TQFF_ADDR_FF_GAIN) gain <= pwdata[15:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_bad;
      psel && penable && paddr > TQFF_ADDR_TQ_OUT;
   endsequence
   a_bad_addr: assert property (s_bad |-> pslverr) else $error("pslverr missing");
   a_ready_high: assert property (psel |-> pready) else $error("pready low");
   a_ff_off: assert property (sample_en && (src == 2'h0 || src == 2'h3 || gain == 16'h0000)
      |=> ff_term == 16'h0000) else $error("ff term not zero");
   a_out_hold: assert property (!sample_en |=> $stable(ff_term) && $stable(torque_out)) else $error("moved");
   a_tdof_trq: assert property (ctrl_mode == TQFF_MODE_TRQ |=> !tdof_active) else $error("tdof on");
   a_coef_trq: assert property (ctrl_mode == TQFF_MODE_TRQ |=> tdof_coef_out == TQFF_TDOF_FULL)
      else $error("coef not full");
   a_tdof_match: assert property (tdof_coef_valid |-> tdof_active == (tdof_coef_out != TQFF_TDOF_FULL))
      else $error("tdof mismatch");
   a_valid_keep: assert property (tdof_coef_valid |=> tdof_coef_valid) else $error("valid dropped");
endmodule // tqff_loop_monitor
bind tqff_loop tqff_loop_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .sample_en, .ctrl_mode, .ff_term, .torque_out, .tdof_active, .tdof_coef_valid, .tdof_coef_out);

// >>> dv/tb_top.sv
// self-checking bench for tqff_loop
// assumes a 250 MHz pclk and zero wait APB
`timescale 1ns/100ps
module tb_top;
   import tqff_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sample_en = 1'b0;
   logic pready, pslverr, err_seen, tdof_active, tdof_coef_valid;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0] ctrl_mode = 2'h0;
   logic [15:0] speed_cmd = 16'h0, pos_ctrl_out = 16'h0, torque_offset = 16'h0, reg_torque = 16'h0;
   logic [7:0] polarity = 8'h00;
   logic [15:0] torque_out, ff_term, tdof_coef_out, coef, ffx;
   int err_total = 0, n_compared = 0, seed = 32'h916a5c17, x, g, s, m;
   always #2 pclk = ~pclk;
   tqff_loop u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sample_en, .ctrl_mode, .speed_cmd, .pos_ctrl_out, .torque_offset, .polarity, .reg_torque, .torque_out,
      .ff_term, .tdof_active, .tdof_coef_valid, .tdof_coef_out);
   // *****
   // helpers
   // *****
   function automatic logic [15:0] sat(input int v);
      return (v > 32767) ? TQFF_TQ_MAX : (v < -32768) ? TQFF_TQ_MIN : 16'(v);
   endfunction
   function automatic int filt_step(input int acc, input int src, input int sh);
      return acc + ((src - acc) >>> sh);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      n_compared++;
      if (v !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, v);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      err_seen = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, TQFF_ADDR_TDOF_COEF, 32'h0);
      chk("coef", {16'h0, TQFF_TDOF_FULL}, rd);
      apb(1'b1, 12'h020, 32'h1);
      chk("err", 32'h1, {31'h0, err_seen});
      apb(1'b0, 12'h020, 32'h0);
      chk("bad", TQFF_RDATA_ZERO, rd);
      apb(1'b1, TQFF_ADDR_FF_FILT, 32'h5);
      apb(1'b0, TQFF_ADDR_FF_FILT, 32'h0);
      chk("filt", 32'h5, rd);
      apb(1'b1, TQFF_ADDR_FF_FILT, 32'h0);
      for (int i = 0; i < 24; i++) begin
         s = i / 3 % 4;
         ctrl_mode <= 2'(i % 3);
         speed_cmd <= 16'($random(seed));
         pos_ctrl_out <= 16'($random(seed));
         torque_offset <= 16'($random(seed));
         polarity <= 8'($random(seed));
         reg_torque <= 16'($random(seed));
         g = (i % 4 == 0) ? 0 : (i < 12) ? 1000 : $unsigned($random(seed)) % 2001;
         coef = (i % 5 == 0) ? TQFF_TDOF_FULL : 16'($random(seed));
         apb(1'b1, TQFF_ADDR_SRC_SEL, 32'(s));
         apb(1'b1, TQFF_ADDR_FF_GAIN, 32'(g));
         apb(1'b1, TQFF_ADDR_TDOF_COEF, {16'h0, coef});
         repeat (3) begin
            @(posedge pclk);
            sample_en <= 1'b1;
            @(posedge pclk);
            sample_en <= 1'b0;
         end
         @(negedge pclk);
         x = (s == 1) ? ((ctrl_mode == TQFF_MODE_POS) ? int'($signed(pos_ctrl_out)) : int'($signed(speed_cmd)))
            : (s == 2) ? (polarity[TQFF_POL_BIT] ? -int'($signed(torque_offset)) : int'($signed(torque_offset)))
            : 0;
         ffx = sat(x * g / 1000);
         chk("ff", {16'h0, ffx}, {16'h0, ff_term});
         chk("tq", {16'h0, sat(int'($signed(reg_torque)) + int'($signed(ffx)))}, {16'h0, torque_out});
         chk("cf", {16'h0, (ctrl_mode == TQFF_MODE_TRQ) ? TQFF_TDOF_FULL : coef}, {16'h0, tdof_coef_out});
         apb(1'b0, TQFF_ADDR_STATUS, 32'h0);
         chk("st", {30'h0, 1'b1, ctrl_mode != TQFF_MODE_TRQ && coef != TQFF_TDOF_FULL}, rd);
      end
      // filter with shift one; the code three pass left the accumulator at zero
      polarity <= 8'h00;
      torque_offset <= {2'b00, 14'($random(seed))};
      apb(1'b1, TQFF_ADDR_FF_FILT, 32'h1);
      apb(1'b1, TQFF_ADDR_SRC_SEL, {30'h0, TQFF_SRC_EXTERNAL});
      apb(1'b1, TQFF_ADDR_FF_GAIN, {16'h0, TQFF_GAIN_UNITY});
      m = 0;
      repeat (3) begin
         @(posedge pclk);
         sample_en <= 1'b1;
         @(posedge pclk);
         sample_en <= 1'b0;
         @(negedge pclk);
         chk("fl", {16'h0, 16'(m)}, {16'h0, ff_term});
         m = filt_step(m, int'(torque_offset), 1);
      end
      report_and_stop();
   end
endmodule // tb_top
